// file: pld_consts.svh
// constants for the synthesizer lock supervision and receive path control block
// assumes a single 10 MHz clock and a plain strobe register port with byte addresses
`ifndef PLD_CONSTS_SVH
`define PLD_CONSTS_SVH

// clock and timing
`define PLD_CLK_PERIOD_NS 100
`define PLD_HYST_SETTLE_NS 400
`define PLD_HYST_SETTLE_CYC ((`PLD_HYST_SETTLE_NS + `PLD_CLK_PERIOD_NS - 1) / `PLD_CLK_PERIOD_NS)

// register byte addresses
`define PLD_ADDR_W 8
`define PLD_OFS_CTRL 8'h00
`define PLD_OFS_LOCK_TARGET 8'h04
`define PLD_OFS_UNLOCK_TOL 8'h08
`define PLD_OFS_STATUS 8'h0c
`define PLD_OFS_IRQ_STATUS 8'h10
`define PLD_OFS_IRQ_ENABLE 8'h14
`define PLD_OFS_IRQ_CLEAR 8'h18

// control register fields
`define PLD_CTRL_LOCK_OBSERVE 0
`define PLD_CTRL_DET_POLARITY 1
`define PLD_CTRL_OSC_CUR_LO 2
`define PLD_CTRL_OSC_CUR_HI 5
`define PLD_CTRL_GAIN_SOURCE 6
`define PLD_CTRL_INT_GAIN 7
`define PLD_CTRL_GAIN_HYST 8
`define PLD_CTRL_DATA_INVERT 9
`define PLD_CTRL_PEAK_MODE 10

// status register fields
`define PLD_STAT_LOCK 0
`define PLD_STAT_GAIN 1
`define PLD_STAT_LOCK_ZERO 2
`define PLD_STAT_UNLOCK_ZERO 3
`define PLD_STAT_PEAK_ACTIVE 4

// interrupt bits
`define PLD_IRQ_W 2
`define PLD_IRQ_LOCK_GAINED 0
`define PLD_IRQ_LOCK_LOST 1

// reset values
`define PLD_RST_LOCK_TARGET 8'h10
`define PLD_RST_UNLOCK_TOL 8'h04
`define PLD_RST_OSC_CUR 4'h0

`endif

// file: pld_pkg.sv
// types shared by the lock supervision and receive path control block
// assumes pld_consts.svh supplies the numeric layout
package pld_pkg;

  typedef struct packed {
    logic peak_mode;
    logic data_invert;
    logic gain_hysteresis_enable;
    logic internal_gain_bit;
    logic gain_source_select;
    logic [3:0] oscillator_current;
    logic detector_polarity;
    logic lock_observe_select;
  } pld_cfg_t;

  typedef struct packed {
    logic demod_switch_one;
    logic demod_switch_two;
    logic peak_detector;
    logic peak_output_pin;
  } pld_demod_t;

  typedef enum logic {
    PLD_DEMOD_STANDARD,
    PLD_DEMOD_PEAK
  } pld_demod_mode_t;

endpackage : pld_pkg

// file: pld_down_counter.sv
// loadable down counter that stops at zero
// assumes load has priority over decrement
`timescale 1ns/1ns
`default_nettype none

module pld_down_counter #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // control
  input wire logic i_load,
  input wire logic [W-1:0] i_load_value,
  input wire logic i_dec,
  // state
  output logic [W-1:0] o_count,
  output logic o_zero
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;

  always_comb begin
    next_count = count;
    if (i_load) begin
      next_count = i_load_value;
    end else if (i_dec && (count != '0)) begin
      next_count = count - W'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign o_count = count;
  assign o_zero = (count == '0);

endmodule // pld_down_counter

`default_nettype wire

// file: pld_gain_filter.sv
// external gain pin conditioning, digital stand-in for the input hysteresis
// assumes the pin is already synchronous to the clock
`timescale 1ns/1ns
`default_nettype none

module pld_gain_filter #(
  parameter int SETTLE = 4
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // pin and mode
  input wire logic i_pin,
  input wire logic i_hyst_en,
  // filtered level
  output logic o_level
);

  localparam int CW = $clog2(SETTLE + 1);

  logic level;
  logic next_level;
  logic [CW-1:0] run;
  logic [CW-1:0] next_run;

  // with hysteresis on, a change must persist before it is taken,
  // which rejects chatter around the threshold at the cost of latency
  always_comb begin
    next_level = level;
    next_run = '0;
    if (!i_hyst_en) begin
      next_level = i_pin;
    end else if (i_pin != level) begin
      if (run == CW'(SETTLE - 1)) begin
        next_level = i_pin;
      end else begin
        next_run = run + CW'(1);
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      level <= 1'b0;
      run <= '0;
    end else begin
      level <= next_level;
      run <= next_run;
    end
  end

  assign o_level = level;

endmodule // pld_gain_filter

`default_nettype wire

// file: pld_top.sv
// synthesizer lock supervision and receive path control
// assumes up/down pulses sampled on the reference clock, one clock domain
//
// Summary of operation
// - consecutive up/down keeps reloading unlock counter
// - non-consecutive pulses decrement unlock counter each clock
// - tolerance sets allowed non-consecutive clocks before unlock
// - observe select zero latches lock for active period
// - other observe value tracks lock, drops on unlock
// - gain source bit picks pin or internal bit
// - internal source uses internal bit, ignores pin
// - external source applies hysteresis when enabled
// - transmit mode shorts amplifier input
// - data invert bit inverts transmitted data
// - standard demodulation closes both switches
// - peak mode enables detector, opens second switch
// - peak mode only in programmable mode
// - lock counter counts overlaps, locks at target, reloads
// - programmable mode drives lock on shared pin
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "pld_consts.svh"

module pld_top #(
  parameter int CNT_W = 8,
  parameter int HYST_SETTLE = `PLD_HYST_SETTLE_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // register port
  input wire logic [`PLD_ADDR_W-1:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // phase detector pulses
  input wire logic i_up,
  input wire logic i_down,
  // transceiver state
  input wire logic i_active,
  input wire logic i_prog_mode,
  input wire logic i_tx_mode,
  // gain pin and transmit data
  input wire logic i_external_gain_pin,
  input wire logic i_tx_data,
  // shared frequency select / lock pin
  output logic o_select_or_lock_pin_out,
  output logic o_select_or_lock_pin_oe,
  // synthesizer settings
  output logic o_detector_polarity,
  output logic [3:0] o_oscillator_current,
  // receive front end and demodulator
  output logic o_lna_gain_high,
  output logic o_lna_input_short,
  output logic o_demod_switch_one,
  output logic o_demod_switch_two,
  output logic o_peak_detector,
  output logic o_peak_output_pin,
  // transmit data path
  output logic o_tx_data,
  // interrupt
  output logic o_irq
);

  function automatic logic hit(input logic [`PLD_ADDR_W-1:0] a,
                               input logic [`PLD_ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  // register state
  pld_pkg::pld_cfg_t cfg;
  pld_pkg::pld_cfg_t next_cfg;
  logic [CNT_W-1:0] lock_count_target;
  logic [CNT_W-1:0] next_lock_count_target;
  logic [CNT_W-1:0] unlock_tolerance_count;
  logic [CNT_W-1:0] next_unlock_tolerance_count;
  logic [`PLD_IRQ_W-1:0] irq_status;
  logic [`PLD_IRQ_W-1:0] next_irq_status;
  logic [`PLD_IRQ_W-1:0] irq_enable;
  logic [`PLD_IRQ_W-1:0] next_irq_enable;
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  // lock supervision state
  logic active_q;
  logic lock_indicator;
  logic next_lock_indicator;
  logic lock_zero;
  logic unlock_zero;
  logic active_start;
  logic hold_clear;
  logic overlap;
  logic consecutive;
  logic lock_cond;
  logic unlock_event;
  logic lock_load;
  logic unlock_load;

  // pin side state
  logic gain_pin_level;
  logic gain_state;
  pld_pkg::pld_demod_mode_t demod_mode;
  pld_pkg::pld_demod_t demod;
  pld_pkg::pld_demod_t next_demod;
  logic next_gain;
  logic next_short;
  logic next_tx_data;
  logic next_pin_out;
  logic next_pin_oe;
  logic next_irq;
  logic next_active_q;

  // pulse qualification: overlap feeds the lock counter, a lone up or
  // down pulse is the non-consecutive case watched by the unlock counter
  assign overlap = i_up & i_down;
  assign consecutive = ~(i_up ^ i_down);
  assign active_start = i_active & ~active_q;
  assign hold_clear = ~i_active | active_start;

  assign lock_cond = lock_zero & ~hold_clear;
  assign unlock_event = ~consecutive & unlock_zero & ~hold_clear;
  assign lock_load = hold_clear | unlock_event;
  assign unlock_load = hold_clear | consecutive;

  pld_down_counter #(
    .W(CNT_W)
  ) u_lock_counter (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_load(lock_load),
    .i_load_value(lock_count_target),
    .i_dec(overlap),
    .o_count(),
    .o_zero(lock_zero)
  );

  pld_down_counter #(
    .W(CNT_W)
  ) u_unlock_supervision_counter (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_load(unlock_load),
    .i_load_value(unlock_tolerance_count),
    .i_dec(~consecutive),
    .o_count(),
    .o_zero(unlock_zero)
  );

  pld_gain_filter #(
    .SETTLE(HYST_SETTLE)
  ) u_gain_filter (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_pin(i_external_gain_pin),
    .i_hyst_en(cfg.gain_hysteresis_enable),
    .o_level(gain_pin_level)
  );

  // lock indicator
  always_comb begin
    next_active_q = i_active;
    next_lock_indicator = lock_indicator;
    if (hold_clear) begin
      next_lock_indicator = 1'b0;
    end else if (!cfg.lock_observe_select) begin
      next_lock_indicator = lock_indicator | lock_cond;
    end else if (unlock_event) begin
      next_lock_indicator = 1'b0;
    end else if (lock_cond) begin
      next_lock_indicator = 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      active_q <= 1'b0;
      lock_indicator <= 1'b0;
    end else begin
      active_q <= next_active_q;
      lock_indicator <= next_lock_indicator;
    end
  end

  // registers and interrupts
  always_comb begin
    next_cfg = cfg;
    next_lock_count_target = lock_count_target;
    next_unlock_tolerance_count = unlock_tolerance_count;
    next_irq_enable = irq_enable;
    next_irq_status = irq_status;
    next_rdata = 32'h0000_0000;
    if (i_wr) begin
      if (hit(i_addr, `PLD_OFS_CTRL)) begin
        next_cfg.lock_observe_select = i_wdata[`PLD_CTRL_LOCK_OBSERVE];
        next_cfg.detector_polarity = i_wdata[`PLD_CTRL_DET_POLARITY];
        next_cfg.oscillator_current = i_wdata[`PLD_CTRL_OSC_CUR_HI:`PLD_CTRL_OSC_CUR_LO];
        next_cfg.gain_source_select = i_wdata[`PLD_CTRL_GAIN_SOURCE];
        next_cfg.internal_gain_bit = i_wdata[`PLD_CTRL_INT_GAIN];
        next_cfg.gain_hysteresis_enable = i_wdata[`PLD_CTRL_GAIN_HYST];
        next_cfg.data_invert = i_wdata[`PLD_CTRL_DATA_INVERT];
        next_cfg.peak_mode = i_wdata[`PLD_CTRL_PEAK_MODE];
      end
      if (hit(i_addr, `PLD_OFS_LOCK_TARGET)) begin
        next_lock_count_target = i_wdata[CNT_W-1:0];
      end
      if (hit(i_addr, `PLD_OFS_UNLOCK_TOL)) begin
        next_unlock_tolerance_count = i_wdata[CNT_W-1:0];
      end
      if (hit(i_addr, `PLD_OFS_IRQ_ENABLE)) begin
        next_irq_enable = i_wdata[`PLD_IRQ_W-1:0];
      end
      if (hit(i_addr, `PLD_OFS_IRQ_CLEAR)) begin
        next_irq_status = irq_status & ~i_wdata[`PLD_IRQ_W-1:0];
      end
    end
    // events are applied after the clear so a same-cycle set survives
    if (next_lock_indicator && !lock_indicator) begin
      next_irq_status[`PLD_IRQ_LOCK_GAINED] = 1'b1;
    end
    if (lock_indicator && unlock_event && cfg.lock_observe_select) begin
      next_irq_status[`PLD_IRQ_LOCK_LOST] = 1'b1;
    end
    if (i_rd) begin
      if (hit(i_addr, `PLD_OFS_CTRL)) begin
        next_rdata[`PLD_CTRL_PEAK_MODE:0] = cfg;
      end else if (hit(i_addr, `PLD_OFS_LOCK_TARGET)) begin
        next_rdata[CNT_W-1:0] = lock_count_target;
      end else if (hit(i_addr, `PLD_OFS_UNLOCK_TOL)) begin
        next_rdata[CNT_W-1:0] = unlock_tolerance_count;
      end else if (hit(i_addr, `PLD_OFS_STATUS)) begin
        next_rdata[`PLD_STAT_LOCK] = lock_indicator;
        next_rdata[`PLD_STAT_GAIN] = gain_state;
        next_rdata[`PLD_STAT_LOCK_ZERO] = lock_zero;
        next_rdata[`PLD_STAT_UNLOCK_ZERO] = unlock_zero;
        next_rdata[`PLD_STAT_PEAK_ACTIVE] = demod.peak_detector;
      end else if (hit(i_addr, `PLD_OFS_IRQ_STATUS)) begin
        next_rdata[`PLD_IRQ_W-1:0] = irq_status;
      end else if (hit(i_addr, `PLD_OFS_IRQ_ENABLE)) begin
        next_rdata[`PLD_IRQ_W-1:0] = irq_enable;
      end
    end
    next_irq = |(next_irq_status & next_irq_enable);
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      cfg <= '0;
      cfg.oscillator_current <= `PLD_RST_OSC_CUR;
      lock_count_target <= CNT_W'(`PLD_RST_LOCK_TARGET);
      unlock_tolerance_count <= CNT_W'(`PLD_RST_UNLOCK_TOL);
      irq_enable <= '0;
      irq_status <= '0;
      rdata <= 32'h0000_0000;
      o_irq <= 1'b0;
    end else begin
      cfg <= next_cfg;
      lock_count_target <= next_lock_count_target;
      unlock_tolerance_count <= next_unlock_tolerance_count;
      irq_enable <= next_irq_enable;
      irq_status <= next_irq_status;
      rdata <= next_rdata;
      o_irq <= next_irq;
    end
  end

  assign o_rdata = rdata;

  // pin side decoding
  assign demod_mode = (cfg.peak_mode && i_prog_mode) ?
                      pld_pkg::PLD_DEMOD_PEAK : pld_pkg::PLD_DEMOD_STANDARD;

  always_comb begin
    unique case (demod_mode)
      pld_pkg::PLD_DEMOD_PEAK: begin
        next_demod = '{demod_switch_one: 1'b1, demod_switch_two: 1'b0,
                       peak_detector: 1'b1, peak_output_pin: 1'b1};
      end
      pld_pkg::PLD_DEMOD_STANDARD: begin
        next_demod = '{demod_switch_one: 1'b1, demod_switch_two: 1'b1,
                       peak_detector: 1'b0, peak_output_pin: 1'b0};
      end
    endcase
    if (cfg.gain_source_select) begin
      next_gain = cfg.internal_gain_bit;
    end else begin
      next_gain = gain_pin_level;
    end
    next_short = i_tx_mode;
    next_tx_data = i_tx_data ^ cfg.data_invert;
    next_pin_oe = i_prog_mode;
    next_pin_out = i_prog_mode & next_lock_indicator;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      demod <= '{demod_switch_one: 1'b1, demod_switch_two: 1'b1,
                 peak_detector: 1'b0, peak_output_pin: 1'b0};
      gain_state <= 1'b0;
      o_lna_input_short <= 1'b0;
      o_tx_data <= 1'b0;
      o_select_or_lock_pin_oe <= 1'b0;
      o_select_or_lock_pin_out <= 1'b0;
    end else begin
      demod <= next_demod;
      gain_state <= next_gain;
      o_lna_input_short <= next_short;
      o_tx_data <= next_tx_data;
      o_select_or_lock_pin_oe <= next_pin_oe;
      o_select_or_lock_pin_out <= next_pin_out;
    end
  end

  assign o_lna_gain_high = gain_state;
  assign o_demod_switch_one = demod.demod_switch_one;
  assign o_demod_switch_two = demod.demod_switch_two;
  assign o_peak_detector = demod.peak_detector;
  assign o_peak_output_pin = demod.peak_output_pin;
  assign o_detector_polarity = cfg.detector_polarity;
  assign o_oscillator_current = cfg.oscillator_current;

endmodule // pld_top

`default_nettype wire

// file: pld_checker_assertions.sv
// concurrent checks on the pld_top ports
// assumes one clock domain and the synchronous active-high reset of pld_top
`timescale 1ns/1ns
`default_nettype none

module pld_checker (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // watched inputs
  input wire logic i_rd,
  input wire logic i_up,
  input wire logic i_down,
  input wire logic i_active,
  input wire logic i_prog_mode,
  input wire logic i_tx_mode,
  // watched outputs
  input wire logic [31:0] o_rdata,
  input wire logic o_select_or_lock_pin_out,
  input wire logic o_select_or_lock_pin_oe,
  input wire logic o_lna_input_short,
  input wire logic o_demod_switch_one,
  input wire logic o_demod_switch_two,
  input wire logic o_peak_detector,
  input wire logic o_peak_output_pin
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  chk_short_in_tx: assert property (1'b1 |=> o_lna_input_short == $past(i_tx_mode))
    else $error("input short does not track tx mode");
  chk_oe_prog_mode: assert property (1'b1 |=> o_select_or_lock_pin_oe == $past(i_prog_mode))
    else $error("pin enable does not track programmable mode");
  chk_pin_off_alone: assert property (!i_prog_mode |=> !o_select_or_lock_pin_out)
    else $error("lock driven on pin in stand-alone mode");
  chk_alone_std_demod: assert property (!i_prog_mode |=>
    o_demod_switch_one && o_demod_switch_two && !o_peak_detector)
    else $error("peak demodulation outside programmable mode");
  chk_peak_switch_set: assert property (o_peak_detector |->
    o_demod_switch_one && !o_demod_switch_two && o_peak_output_pin)
    else $error("peak mode switch pattern wrong");
  chk_std_switch_set: assert property (!o_peak_detector |->
    o_demod_switch_one && o_demod_switch_two && !o_peak_output_pin)
    else $error("standard mode switch pattern wrong");
  chk_idle_no_lock: assert property (!i_active |=> !o_select_or_lock_pin_out)
    else $error("lock shown outside active mode");
  chk_lock_rise_cause: assert property ($rose(o_select_or_lock_pin_out) |->
    $past(i_active) && $past(i_prog_mode))
    else $error("lock rose without active programmable mode");
  chk_lock_drop_cause: assert property ($fell(o_select_or_lock_pin_out) |->
    !$past(i_active) || !$past(i_prog_mode) || $past(i_up ^ i_down) || $past(i_up ^ i_down, 2))
    else $error("lock dropped with no lone pulse");
  chk_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule // pld_checker

bind pld_top pld_checker u_chk (.i_clk, .i_srst, .i_rd, .i_up, .i_down, .i_active,
  .i_prog_mode, .i_tx_mode, .o_rdata, .o_select_or_lock_pin_out, .o_select_or_lock_pin_oe,
  .o_lna_input_short, .o_demod_switch_one, .o_demod_switch_two, .o_peak_detector,
  .o_peak_output_pin);

`default_nettype wire

// file: pld_pd_model.sv
// phase detector stand-in producing up/down pulse patterns
// assumes the bench picks the pattern; pulses change just after a rising edge
`timescale 1ns/1ns
`default_nettype none

module pld_pd_model (
  // clock
  input wire logic i_clk,
  // pattern: 0 quiet, 1 overlap, 2 lone up, 3 lone down
  input wire logic [1:0] i_mode,
  // pulses
  output logic o_up,
  output logic o_down
);
  // one driver per pulse; the bench holds reset well past the first edge
  always @(posedge i_clk) begin
    o_up <= (i_mode == 2'h1) || (i_mode == 2'h2);
    o_down <= (i_mode == 2'h1) || (i_mode == 2'h3);
  end
endmodule // pld_pd_model

`default_nettype wire

// file: tb_pll_lock_detect_rx_control.sv
// self-checking bench for pld_top: registers, lock supervision, front-end decode
// assumes pld_consts.svh on the include path and the phase detector model beside it
`timescale 1ns/1ns
`default_nettype none
`include "pld_consts.svh"

module tb_pll_lock_detect_rx_control;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_active = 1'b0;
  logic i_prog_mode = 1'b0;
  logic i_tx_mode = 1'b0;
  logic i_gpin = 1'b0;
  logic i_tx_data = 1'b0;
  logic [1:0] pd_mode = 2'h0;
  logic up, down, pin, oe, pol, gain, shrt, sw1, sw2, pk, pkp, txo, irq;
  logic [3:0] osc;
  logic [31:0] rdata;
  int mismatches = 0;
  int n_checks = 0;

  always #50 i_clk = ~i_clk;

  pld_pd_model u_pd (.i_clk(i_clk), .i_mode(pd_mode), .o_up(up), .o_down(down));

  pld_top #(.CNT_W(8), .HYST_SETTLE(4)) u_dut (.i_clk, .i_srst, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata(rdata), .i_up(up), .i_down(down), .i_active, .i_prog_mode, .i_tx_mode,
    .i_external_gain_pin(i_gpin), .i_tx_data, .o_select_or_lock_pin_out(pin),
    .o_select_or_lock_pin_oe(oe), .o_detector_polarity(pol), .o_oscillator_current(osc),
    .o_lna_gain_high(gain), .o_lna_input_short(shrt), .o_demod_switch_one(sw1),
    .o_demod_switch_two(sw2), .o_peak_detector(pk), .o_peak_output_pin(pkp),
    .o_tx_data(txo), .o_irq(irq));

  task automatic finish_test();
    if (mismatches == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe, so look mid-cycle
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    check(rdata, exp);
  endtask

  task automatic settle();
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
  endtask

  // bounded wait for the lock pin; lo is the fewest edges the rules allow
  task automatic wait_pin(input logic lvl, input int lo, input int hi);
    int n = 0;
    while (pin !== lvl && n < hi) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check(n >= lo, 1'b1);
    check(pin, lvl);
    if (pin !== lvl)
      finish_test();
  endtask

  task automatic t_regs();
    rd(`PLD_OFS_CTRL, 32'h0);
    rd(`PLD_OFS_LOCK_TARGET, 32'h10);
    rd(`PLD_OFS_UNLOCK_TOL, 32'h4);
    rd(`PLD_OFS_IRQ_ENABLE, 32'h0);
    rd(`PLD_OFS_IRQ_CLEAR, 32'h0);
    wr(8'h1c, 32'hffff_ffff);
    wr(`PLD_OFS_STATUS, 32'h1f);
    rd(8'h1c, 32'h0);
    rd(`PLD_OFS_STATUS, 32'h0);
    rd(`PLD_OFS_CTRL, 32'h0);
  endtask

  task automatic t_cfg();
    wr(`PLD_OFS_CTRL, 32'h3c);
    settle();
    check(osc, 4'hf);
    check(pol, 1'b0);
    wr(`PLD_OFS_CTRL, 32'h200);
    for (int v = 0; v < 2; v++) begin
      @(posedge i_clk);
      i_tx_data <= v[0];
      settle();
      check(txo, !v[0]);
    end
    check(osc, 4'h0);
    wr(`PLD_OFS_CTRL, 32'h0);
    settle();
    check(txo, 1'b1);
  endtask

  task automatic t_gain();
    wr(`PLD_OFS_CTRL, 32'hc0);
    settle();
    check(gain, 1'b1);
    @(posedge i_clk);
    i_gpin <= 1'b1;
    wr(`PLD_OFS_CTRL, 32'h40);
    settle();
    check(gain, 1'b0);
    wr(`PLD_OFS_CTRL, 32'h0);
    settle();
    check(gain, 1'b1);
    wr(`PLD_OFS_CTRL, 32'h100);
    @(posedge i_clk);
    i_gpin <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_gpin <= 1'b1;
    settle();
    check(gain, 1'b1);
    @(posedge i_clk);
    i_gpin <= 1'b0;
    repeat (8) @(posedge i_clk);
    @(negedge i_clk);
    check(gain, 1'b0);
  endtask

  task automatic t_front();
    @(posedge i_clk);
    i_tx_mode <= 1'b1;
    settle();
    check(shrt, 1'b1);
    @(posedge i_clk);
    i_tx_mode <= 1'b0;
    wr(`PLD_OFS_CTRL, 32'h400);
    settle();
    check({sw1, sw2, pk, pkp}, 4'hc);
    @(posedge i_clk);
    i_prog_mode <= 1'b1;
    settle();
    check({sw1, sw2, pk, pkp}, 4'hb);
    check(oe, 1'b1);
    check(shrt, 1'b0);
    wr(`PLD_OFS_CTRL, 32'h0);
    settle();
    check({sw1, sw2, pk, pkp}, 4'hc);
  endtask

  task automatic t_lock_cont();
    wr(`PLD_OFS_LOCK_TARGET, 32'h3);
    wr(`PLD_OFS_UNLOCK_TOL, 32'h5);
    wr(`PLD_OFS_IRQ_ENABLE, 32'h3);
    wr(`PLD_OFS_CTRL, 32'h1);
    @(posedge i_clk);
    i_active <= 1'b1;
    pd_mode <= 2'h1;
    wait_pin(1'b1, 3, 10);
    check(irq, 1'b1);
    rd(`PLD_OFS_STATUS, 32'h5);
    @(posedge i_clk);
    pd_mode <= 2'h0;
    repeat (20) @(posedge i_clk);
    #1;
    check(pin, 1'b1);
    @(posedge i_clk);
    pd_mode <= 2'h2;
    wait_pin(1'b0, 6, 12);
    rd(`PLD_OFS_IRQ_STATUS, 32'h3);
    wr(`PLD_OFS_IRQ_ENABLE, 32'h0);
    settle();
    check(irq, 1'b0);
    rd(`PLD_OFS_IRQ_STATUS, 32'h3);
    wr(`PLD_OFS_IRQ_CLEAR, 32'h3);
    rd(`PLD_OFS_IRQ_STATUS, 32'h0);
  endtask

  task automatic t_lock_latch();
    wr(`PLD_OFS_CTRL, 32'h0);
    @(posedge i_clk);
    i_active <= 1'b0;
    pd_mode <= 2'h1;
    repeat (8) @(posedge i_clk);
    @(negedge i_clk);
    check(pin, 1'b0);
    @(posedge i_clk);
    i_active <= 1'b1;
    wait_pin(1'b1, 3, 10);
    @(posedge i_clk);
    pd_mode <= 2'h3;
    repeat (20) @(posedge i_clk);
    @(negedge i_clk);
    check(pin, 1'b1);
    @(posedge i_clk);
    i_active <= 1'b0;
    settle();
    check(pin, 1'b0);
  endtask

  initial begin
    repeat (16) @(posedge i_clk);
    i_srst <= 1'b0;
    t_regs();
    t_cfg();
    t_gain();
    t_front();
    t_lock_cont();
    t_lock_latch();
    finish_test();
  end
endmodule // tb_pll_lock_detect_rx_control

`default_nettype wire
